/* core/bbm_mode_ctrl.sv */
// Battery backup mode control: switchover decision and backup-time enables.
`timescale 1ns/1ps
module bbm_mode_ctrl
  import bbm_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     resetn_i,
  input  wire logic     cfg_write_i,
  input  wire logic     backup_bus_inhibit_i,
  input  wire logic     switchover_select_i,
  input  wire bbm_cmp_t cmp_i,
  output logic          backup_bus_inhibit_o,
  output logic          switchover_select_o,
  output bbm_en_t       en_o
);

  typedef enum logic [1:0] {
    BBM_ST_MAIN   = 2'b01,
    BBM_ST_BACKUP = 2'b10
  } bbm_state_t;

  logic       inhibit_ff;
  logic       swsel_ff;
  bbm_state_t state_ff;
  bbm_state_t nxt_state;
  bbm_cmp_t   cmp_s;
  bbm_en_t    en_ff;
  bbm_en_t    nxt_en;
  logic [1:0] mode;

  // Switchover condition for a mode; legacy hands over as soon as main drops under backup
  function automatic logic bbm_go_backup(input logic sw, input bbm_cmp_t c);
    if (sw) begin
      bbm_go_backup = c.vdd_below_bat;
    end else begin
      bbm_go_backup = c.vdd_below_trip;
    end
  endfunction

  // Comparators are asynchronous to our clock
  bbm_sync #(
    .W (BBM_CMP_W)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .async_i  (cmp_i),
    .sync_o   (cmp_s)
  );

  // Mode bits; reset lands in legacy mode B so alarms work out of the box
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      inhibit_ff <= BBM_RST_INHIBIT;
      swsel_ff   <= BBM_RST_SWSEL;
    end else if (cfg_write_i) begin
      inhibit_ff <= backup_bus_inhibit_i;
      swsel_ff   <= switchover_select_i;
    end
  end

  assign mode = {inhibit_ff, swsel_ff};

  // Supply source state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BBM_ST_MAIN: begin
        if (bbm_go_backup(swsel_ff, cmp_s)) begin
          nxt_state = BBM_ST_BACKUP;
        end
      end
      BBM_ST_BACKUP: begin
        if (!bbm_go_backup(swsel_ff, cmp_s)) begin
          nxt_state = BBM_ST_MAIN;
        end
      end
      default: nxt_state = BBM_ST_MAIN;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= BBM_ST_MAIN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Enables from the next state so they track the source with no extra lag
  always_comb begin
    logic bk;
    bk     = (nxt_state == BBM_ST_BACKUP);
    nxt_en = '0;
    nxt_en.on_backup         = bk;
    nxt_en.low_voltage_reset = cmp_s.vdd_below_reset;
    case (mode)
      BBM_MODE_A: begin
        // Standard: only timekeeping survives in backup
        nxt_en.bus_enable   = !bk;
        nxt_en.mem_enable   = !bk;
        nxt_en.irq_enable   = !bk;
        nxt_en.alarm_enable = !bk;
      end
      BBM_MODE_B: begin
        nxt_en.bus_enable   = !bk || cmp_s.bat_above_reset;
        nxt_en.mem_enable   = 1'b1;
        nxt_en.irq_enable   = 1'b1;
        nxt_en.alarm_enable = 1'b1;
      end
      BBM_MODE_C: begin
        // Interrupt output and alarms kept; standard trip switchover otherwise
        nxt_en.bus_enable   = !bk;
        nxt_en.mem_enable   = !bk;
        nxt_en.irq_enable   = 1'b1;
        nxt_en.alarm_enable = 1'b1;
      end
      BBM_MODE_D: begin
        // Bus only while main supply above both backup and reset levels
        nxt_en.bus_enable   = !bk && !cmp_s.vdd_below_bat;
        nxt_en.mem_enable   = !bk;
        nxt_en.irq_enable   = 1'b1;
        nxt_en.alarm_enable = 1'b1;
      end
      default: nxt_en = '0;
    endcase
    // Reset level wins over every mode, even where bus-in-backup is set
    if (cmp_s.vdd_below_reset) begin
      nxt_en.bus_enable = 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_ff <= '0;
    end else begin
      en_ff <= nxt_en;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      backup_bus_inhibit_o <= BBM_RST_INHIBIT;
      switchover_select_o  <= BBM_RST_SWSEL;
    end else begin
      backup_bus_inhibit_o <= inhibit_ff;
      switchover_select_o  <= swsel_ff;
    end
  end

  assign en_o = en_ff;

endmodule

/* core/bbm_pkg.sv */
// Package for the battery backup mode control block: modes, carriers, constants.
package bbm_pkg;

  // Mode codes built from {backup_bus_inhibit, switchover_select}
  localparam logic [1:0] BBM_MODE_A = 2'h0;
  localparam logic [1:0] BBM_MODE_B = 2'h1;
  localparam logic [1:0] BBM_MODE_C = 2'h2;
  localparam logic [1:0] BBM_MODE_D = 2'h3;

  // Power-up defaults: legacy switchover, bus allowed in backup (mode B)
  localparam logic       BBM_RST_INHIBIT = 1'h0;
  localparam logic       BBM_RST_SWSEL   = 1'h1;

  // Synchroniser depth
  localparam int         BBM_SYNC_STAGES = 2;

  // Supply comparator levels, as delivered by the analog monitors
  typedef struct packed {
    logic vdd_below_trip;   // Main supply under trip_threshold
    logic vdd_below_bat;    // Main supply under backup supply
    logic vdd_below_reset;  // Main supply under low_supply_reset_level
    logic bat_above_reset;  // Backup supply above low_supply_reset_level
  } bbm_cmp_t;

  // Enables handed to the rest of the chip
  typedef struct packed {
    logic on_backup;        // Core powered from backup input
    logic bus_enable;       // Two-wire serial bus may respond
    logic mem_enable;       // Nonvolatile memory read/write allowed
    logic irq_enable;       // interrupt_frequency_output allowed
    logic alarm_enable;     // Alarm generation allowed
    logic low_voltage_reset;// Main supply under reset level
  } bbm_en_t;

  localparam int BBM_CMP_W = $bits(bbm_cmp_t);

endpackage

/* core/bbm_sync.sv */
// Two-stage level synchroniser for a vector of comparator levels.
`timescale 1ns/1ps
module bbm_sync
  import bbm_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

/* verif/bbm_monitor.sv */
// Checker for the backup mode control outputs.
`timescale 1ns/1ps
module bbm_monitor
  import bbm_pkg::*;
(
  input wire logic     clock_i,
  input wire logic     resetn_i,
  input wire bbm_cmp_t cmp_i,
  input wire logic     backup_bus_inhibit_o,
  input wire logic     switchover_select_o,
  input wire bbm_en_t  en_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire [1:0] mode = {backup_bus_inhibit_o, switchover_select_o};
  // Inputs and mode held long enough for the synchroniser to settle
  sequence steady;
    ($stable(cmp_i) && $stable(mode))[*5];
  endsequence
  lvr_bus_a: assert property (steady ##0 cmp_i.vdd_below_reset |-> !en_o.bus_enable && en_o.low_voltage_reset)
    else $error("bus live under reset level");
  std_switch_a: assert property (steady ##0 !switchover_select_o |-> en_o.on_backup == cmp_i.vdd_below_trip)
    else $error("standard switchover wrong");
  legacy_switch_a: assert property (steady ##0 switchover_select_o |-> en_o.on_backup == cmp_i.vdd_below_bat)
    else $error("legacy switchover wrong");
  mode_a_quiet_a: assert property (steady ##0 mode == BBM_MODE_A && en_o.on_backup |-> !(en_o.bus_enable || en_o.mem_enable))
    else $error("mode A not quiet");
  mode_c_irq_a: assert property (steady ##0 mode == BBM_MODE_C && en_o.on_backup |-> !en_o.mem_enable && en_o.irq_enable)
    else $error("mode C enables wrong");
  mode_b_live_a: assert property (steady ##0 mode == BBM_MODE_B && en_o.on_backup |-> en_o.mem_enable && en_o.alarm_enable)
    else $error("mode B enables wrong");
  mode_d_bus_a: assert property (steady ##0 mode == BBM_MODE_D |-> en_o.bus_enable == !(cmp_i.vdd_below_bat || cmp_i.vdd_below_reset))
    else $error("mode D bus wrong");
  reset_mode_a: assert property ($rose(resetn_i) |-> mode == BBM_MODE_B)
    else $error("reset mode wrong");
  sync_delay_a: assert property ($rose(cmp_i.vdd_below_reset) ##1 cmp_i.vdd_below_reset[*3] |-> en_o.low_voltage_reset)
    else $error("reset level late");
endmodule
bind bbm_mode_ctrl bbm_monitor MON (.clock_i(clock_i), .resetn_i(resetn_i), .cmp_i(cmp_i),
  .backup_bus_inhibit_o(backup_bus_inhibit_o), .switchover_select_o(switchover_select_o), .en_o(en_o));

/* verif/bbm_supply_model.sv */
// Supply monitor model: supply levels in millivolts to comparator levels.
`timescale 1ns/1ps
module bbm_supply_model
  import bbm_pkg::*;
#(
  parameter int TRIP_MV  = 2200,
  parameter int RESET_MV = 2900
) (
  input  wire logic [15:0] vdd_mv_i,
  input  wire logic [15:0] bat_mv_i,
  output bbm_cmp_t         cmp_o
);
  // Ideal comparators; no hysteresis, so edge cases sit exactly on a level
  assign cmp_o = {vdd_mv_i < TRIP_MV, vdd_mv_i < bat_mv_i, vdd_mv_i < RESET_MV, bat_mv_i > RESET_MV};
endmodule

/* verif/test_battery_backup_mode_control.sv */
// Testbench for the battery backup mode control block.
`timescale 1ns/1ps
module test_battery_backup_mode_control;
  import bbm_pkg::*;
  logic        clock_i = 0, resetn_i = 0, cfg_write_i = 0, inh = 0, sws = 0, inh_o, sws_o;
  logic [15:0] vdd_mv = 16'hce4, bat_mv = 16'hbb8;
  bbm_cmp_t    cmp;
  bbm_en_t     en_o;
  int          bad_count = 0, samples_checked = 0;
  always #10 clock_i = ~clock_i;
  bbm_supply_model SUP (.vdd_mv_i(vdd_mv), .bat_mv_i(bat_mv), .cmp_o(cmp));
  bbm_mode_ctrl DUT (.clock_i(clock_i), .resetn_i(resetn_i), .cfg_write_i(cfg_write_i),
    .backup_bus_inhibit_i(inh), .switchover_select_i(sws), .cmp_i(cmp),
    .backup_bus_inhibit_o(inh_o), .switchover_select_o(sws_o), .en_o(en_o));
  // Masked compare; unchecked bits are left free
  task automatic chk(input bbm_en_t seen, input bbm_en_t exp, input bbm_en_t msk);
    samples_checked++;
    if ((seen & msk) !== (exp & msk)) begin
      bad_count++;
      $display("FAIL %0t enables %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic [1:0] m);
    @(posedge clock_i) #1;
    cfg_write_i = 1;
    {inh, sws} = m;
    @(posedge clock_i) #1 cfg_write_i = 0;
    // Enables pick up the stored mode one edge after the store
    @(posedge clock_i) #1;
  endtask
  // Six edges cover the three-edge comparator path with margin
  task automatic lvl(input logic [15:0] v, input logic [15:0] b);
    @(posedge clock_i) #1 {vdd_mv, bat_mv} = {v, b};
    repeat (6) @(posedge clock_i);
    #1;
  endtask
  task automatic t_mode_a;
    cfg(BBM_MODE_A);
    lvl(16'h7d0, 16'hbb8);
    chk(en_o, 6'h21, 6'h39);
    $display("mode A done");
  endtask
  task automatic t_mode_c;
    cfg(BBM_MODE_C);
    chk(en_o, 6'h24, 6'h3c);
    $display("mode C done");
  endtask
  task automatic t_mode_b;
    cfg(BBM_MODE_B);
    chk(en_o, 6'h2f, 6'h3f);
    lvl(16'hc1c, 16'hce4);
    chk(en_o, 6'h30, 6'h30);
    $display("mode B done");
  endtask
  task automatic t_mode_d;
    cfg(BBM_MODE_D);
    chk(en_o, 6'h04, 6'h14);
    lvl(16'hdac, 16'hce4);
    chk(en_o, 6'h10, 6'h10);
    $display("mode D done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #40000;
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clock_i);
    chk(en_o, 6'h00, 6'h3f);
    #1 resetn_i = 1;
    @(posedge clock_i) #1;
    chk({sws_o, inh_o, 4'h0}, 6'h20, 6'h30);
    t_mode_a();
    t_mode_c();
    t_mode_b();
    t_mode_d();
    complete_run;
  end
endmodule
